/* File: logic/bff_params.svh */
// constants for the boot flash fetch block
`ifndef BFF_PARAMS_SVH
`define BFF_PARAMS_SVH
`define BFF_RESET_ADDR      32'hf9000000
`define BFF_BOOT_REGION     32'h00020000
`define BFF_FLASH_ACCESS_NS 120
`define BFF_CLK_PERIOD_NS   4
`define BFF_WAIT_DEFAULT    ((`BFF_FLASH_ACCESS_NS + `BFF_CLK_PERIOD_NS - 1) / `BFF_CLK_PERIOD_NS)
`define BFF_WAIT_W          8
`define BFF_ADDR_W          32
`define BFF_DATA_W          16
`define BFF_BYTES_PER_WORD  2
`endif

/* File: logic/bff_pkg.sv */
// types for the boot flash fetch block
`default_nettype none
`include "bff_params.svh"
package bff_pkg;
    typedef enum logic [1:0]
    {
        BFF_HOLD  = 2'b00,
        BFF_IDLE  = 2'b01,
        BFF_WAIT  = 2'b10,
        BFF_DONE  = 2'b11
    } bff_state_t;

    typedef struct packed
    {
        logic [`BFF_ADDR_W-1:0] addr;
        logic                   ce_n;
        logic                   oe_n;
    } bff_flash_cmd_t;

    typedef struct packed
    {
        logic                   valid;
        logic [`BFF_ADDR_W-1:0] addr;
        logic [`BFF_DATA_W-1:0] data;
    } bff_fetch_rsp_t;
endpackage
`default_nettype wire

/* File: logic/bff_wait_counter.sv */
// wait-state down-counter for one flash read
`timescale 1ns/1ps
`default_nettype none
`include "bff_params.svh"
module bff_wait_counter
    import bff_pkg::*;
#(
    parameter int WAIT_W = `BFF_WAIT_W
)
(
    input  wire logic              clk_sys,  // system clock
    input  wire logic              reset,    // sync reset
    input  wire logic              load,     // start a count
    input  wire logic [WAIT_W-1:0] count_in, // cycles to wait
    output logic                   expired   // count finished
);
    logic [WAIT_W-1:0] count_reg;
    logic [WAIT_W-1:0] count_next;
    wire               is_zero = (count_reg == '0);

    // a zero setting still costs one cycle so data always has a sample edge
    assign count_next = load ? ((count_in == '0) ? WAIT_W'(1) : count_in)
                      : (is_zero ? count_reg : count_reg - WAIT_W'(1));
    assign expired    = is_zero && !load;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            count_reg <= '0;
        else
            count_reg <= count_next;
    end
endmodule
`default_nettype wire

/* File: logic/bff_fetch.sv */
// boot fetch engine for an external parallel program flash
`timescale 1ns/1ps
`default_nettype none
`include "bff_params.svh"
// Rules for this block, its flash and its board
// (RULE1) fetch firmware from external parallel flash
// (RULE2) first fetch at reset start address
// (RULE3) flash provides at least two sectors
// (RULE4) lowest 128 KB holds only bootloader
// (RULE5) boot region may be smaller sectors
// (RULE6) upper sectors hold remaining firmware
// (RULE7) default wait states suit 120 ns
// (RULE8) firmware may program new wait states
// (RULE9) board drives power-good and sense correctly
// (RULE10) hold strobe for wait count, new count next
module bff_fetch
    import bff_pkg::*;
#(
    parameter int ADDR_W = `BFF_ADDR_W,
    parameter int DATA_W = `BFF_DATA_W,
    parameter int WAIT_W = `BFF_WAIT_W
)
(
    input  wire logic              clk_sys,           // system clock
    input  wire logic              reset,             // sync reset
    input  wire logic              supply_ok_in,      // supplies good
    input  wire logic              power_on_sense_in, // power-on sensed
    input  wire logic              fetch_req,         // next word wanted
    input  wire logic              jump_valid,        // load new fetch address
    input  wire logic [ADDR_W-1:0] jump_addr,         // new fetch address
    input  wire logic              wait_wr,           // write wait setting
    input  wire logic [WAIT_W-1:0] wait_wdata,        // new wait setting
    input  wire logic [DATA_W-1:0] flash_dq_in,       // flash data bus
    output logic [ADDR_W-1:0]      flash_addr,        // flash address
    output logic                   flash_ce_n,        // chip enable, low
    output logic                   flash_oe_n,        // output enable, low
    output logic                   fetch_ready,       // engine can take request
    output logic                   fetch_valid,       // word captured, pulse
    output logic [ADDR_W-1:0]      fetch_addr,        // address of word
    output logic [DATA_W-1:0]      fetch_data,        // captured word
    output logic                   in_boot_region,    // fetch inside bootloader
    output logic [WAIT_W-1:0]      wait_setting       // active wait setting
);
    bff_state_t        state_reg;
    bff_state_t        state_next;
    logic [ADDR_W-1:0] pc_reg;
    logic [ADDR_W-1:0] pc_next;
    logic [WAIT_W-1:0] wait_reg;
    logic [WAIT_W-1:0] wait_next;
    logic [WAIT_W-1:0] wait_used_reg;
    bff_flash_cmd_t    cmd_reg;
    bff_flash_cmd_t    cmd_next;
    bff_fetch_rsp_t    rsp_reg;
    bff_fetch_rsp_t    rsp_next;
    logic              expired;

    // fetch only once both power qualifiers agree; see (RULE9)
    wire power_ok = supply_ok_in && power_on_sense_in;
    wire start    = (state_reg == BFF_IDLE) && fetch_req && power_ok;
    wire done     = (state_reg == BFF_WAIT) && expired;
    wire [ADDR_W-1:0] boot_end = ADDR_W'(`BFF_RESET_ADDR) + ADDR_W'(`BFF_BOOT_REGION);
    // a jump in the take cycle is read at once instead of being lost behind the old word
    wire              jump_ok  = jump_valid && (state_reg != BFF_WAIT);
    wire [ADDR_W-1:0] fetch_pc = jump_ok ? jump_addr : pc_reg;

    bff_wait_counter #(.WAIT_W(WAIT_W)) u_wait
    (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .load     (start),
        .count_in (wait_reg),
        .expired  (expired)
    );

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            BFF_HOLD: if (power_ok) state_next = BFF_IDLE;
            BFF_IDLE: if (!power_ok) state_next = BFF_HOLD;
                      else if (start) state_next = BFF_WAIT;
            BFF_WAIT: if (expired) state_next = BFF_DONE;
            BFF_DONE: state_next = power_ok ? BFF_IDLE : BFF_HOLD;
        endcase
    end

    // a write lands in the setting at once but the running access keeps its count
    assign wait_next = wait_wr ? wait_wdata : wait_reg; // see (RULE8)

    // jumps are only taken between accesses so the held address never moves
    assign pc_next = jump_ok ? jump_addr
                   : done ? cmd_reg.addr + ADDR_W'(`BFF_BYTES_PER_WORD)
                   : pc_reg; // see (RULE1)

    assign cmd_next.addr = start ? fetch_pc : cmd_reg.addr; // see (RULE10)
    assign cmd_next.ce_n = !(start || (state_reg == BFF_WAIT && !expired));
    assign cmd_next.oe_n = !(start || (state_reg == BFF_WAIT && !expired));

    assign rsp_next.valid = done;
    assign rsp_next.addr  = done ? cmd_reg.addr : rsp_reg.addr;
    assign rsp_next.data  = done ? flash_dq_in : rsp_reg.data; // see (RULE10)

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_reg     <= BFF_HOLD;
            pc_reg        <= ADDR_W'(`BFF_RESET_ADDR); // see (RULE2)
            wait_reg      <= WAIT_W'(`BFF_WAIT_DEFAULT); // see (RULE7)
            wait_used_reg <= WAIT_W'(`BFF_WAIT_DEFAULT);
            cmd_reg       <= '{addr: ADDR_W'(`BFF_RESET_ADDR), ce_n: 1'b1, oe_n: 1'b1};
            rsp_reg       <= '0;
        end
        else
        begin
            state_reg     <= state_next;
            pc_reg        <= pc_next;
            wait_reg      <= wait_next;
            wait_used_reg <= start ? wait_reg : wait_used_reg; // see (RULE10)
            cmd_reg       <= cmd_next;
            rsp_reg       <= rsp_next;
        end
    end

    assign flash_addr     = cmd_reg.addr;
    assign flash_ce_n     = cmd_reg.ce_n;
    assign flash_oe_n     = cmd_reg.oe_n;
    assign fetch_ready    = (state_reg == BFF_IDLE) && power_ok;
    assign fetch_valid    = rsp_reg.valid;
    assign fetch_addr     = rsp_reg.addr;
    assign fetch_data     = rsp_reg.data;
    // boot image bounds are fixed by the flash layout; see (RULE4)
    assign in_boot_region = (rsp_reg.addr >= ADDR_W'(`BFF_RESET_ADDR)) && (rsp_reg.addr < boot_end);
    assign wait_setting   = wait_used_reg;
endmodule
`default_nettype wire

/* File: sim/bff_fetch_asserts.sv */
// checker for the boot flash fetch block
`timescale 1ns/1ps
`default_nettype none
module bff_fetch_asserts
(
    input wire logic        clk_sys,     // system clock
    input wire logic        reset,       // sync reset
    input wire logic        fetch_req,   // word requested
    input wire logic        fetch_ready, // engine idle
    input wire logic        flash_ce_n,  // chip enable, low
    input wire logic        flash_oe_n,  // output enable, low
    input wire logic [31:0] flash_addr,  // flash address
    input wire logic        fetch_valid, // word captured
    input wire logic [7:0]  wait_setting // active wait setting
);
    logic [7:0] low_reg;
    always_ff @(posedge clk_sys)
        low_reg <= (reset || flash_ce_n) ? 8'h00 : low_reg + 8'h01;
    // one address cycle plus the wait states; a zero setting counts as one
    wire [7:0] low_want = (wait_setting == 8'h00) ? 8'h02 : wait_setting + 8'h01;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_take; fetch_ready && fetch_req; endsequence
    sequence s_read; !flash_ce_n && !flash_oe_n; endsequence
    sequence s_end; flash_ce_n && $past(flash_ce_n) == 1'b0; endsequence
    AST_TAKE: assert property (s_take |=> s_read) else $error("no strobe");
    AST_START: assert property ($past(reset) |-> flash_addr == 32'hf9000000)
        else $error("bad start address");
    AST_DEFWAIT: assert property ($past(reset) |-> wait_setting == 8'h1e)
        else $error("bad default wait");
    AST_STABLE: assert property (s_read |=> $stable(wait_setting))
        else $error("wait changed in read");
    AST_HOLD: assert property ($rose(flash_ce_n) |-> low_reg == low_want)
        else $error("strobe length wrong");
    AST_VALID: assert property (fetch_valid |-> s_end ##1 !fetch_valid)
        else $error("valid misplaced");
endmodule
`default_nettype wire

/* File: sim/bff_flash_model.sv */
// parallel program flash model
`timescale 1ns/1ps
`default_nettype none
module bff_flash_model
(
    input  wire logic        ce_n, // chip enable, low
    input  wire logic        oe_n, // output enable, low
    input  wire logic [31:0] addr, // byte address
    output logic      [15:0] dq    // data bus
);
    logic [15:0] last = 16'h0000;
    // uniform array: boot and firmware sectors answer alike
    always @*
        if (!ce_n && !oe_n)
        begin
            last = addr[15:0] ^ 16'ha5c3;
            dq = last;
        end
        else
            dq = ~last; // released bus never repeats the last word
endmodule
`default_nettype wire

/* File: sim/bff_fetch_test.sv */
// self-checking bench for the boot flash fetch block
`timescale 1ns/1ps
`default_nettype none
module bff_fetch_test
    import bff_pkg::*;
;
    logic        clk_sys = 1'b0, reset = 1'b1, supply_ok_in = 1'b1, power_on_sense_in = 1'b1;
    logic        fetch_req = 1'b0, jump_valid = 1'b0, wait_wr = 1'b0;
    logic [31:0] jump_addr = 32'h0, pc = 32'hf9000000, flash_addr, fetch_addr;
    logic [7:0]  wait_wdata = 8'h00, wait_setting;
    logic [15:0] flash_dq_in, fetch_data;
    logic        flash_ce_n, flash_oe_n, fetch_ready, fetch_valid, in_boot_region;
    int          fails = 0, total_checks = 0, cyc = 0, n = 30;
    bff_fetch_rsp_t e, exp_q[$];
    int          due_q[$];
    always #2 clk_sys = ~clk_sys;
    bff_fetch u_bff_fetch (.clk_sys, .reset, .supply_ok_in, .power_on_sense_in, .fetch_req,
        .jump_valid, .jump_addr, .wait_wr, .wait_wdata, .flash_dq_in, .flash_addr, .flash_ce_n,
        .flash_oe_n, .fetch_ready, .fetch_valid, .fetch_addr, .fetch_data, .in_boot_region,
        .wait_setting);
    bff_flash_model u_bff_flash_model (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .addr(flash_addr),
        .dq(flash_dq_in));
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        if (fails == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic fetch(int k);
        fetch_req = 1'b1;
        repeat (k)
        begin
            while (fetch_ready !== 1'b1) @(negedge clk_sys);
            @(negedge clk_sys);
            exp_q.push_back({1'b1, pc, pc[15:0] ^ 16'ha5c3});
            // strobe spans one address cycle plus the wait states
            due_q.push_back(cyc + n + 1);
            pc += 2;
        end
        fetch_req = 1'b0;
    endtask
    task automatic settle();
        while (exp_q.size() != 0) @(negedge clk_sys);
        @(negedge clk_sys);
    endtask
    always @(negedge clk_sys)
        if (fetch_valid === 1'b1)
        begin
            chk("queue", 32'h1, exp_q.size() != 0);
            e = exp_q.pop_front();
            chk("fetch_addr", e.addr, fetch_addr);
            chk("fetch_data", e.data, fetch_data);
            chk("latency", due_q.pop_front(), cyc);
            chk("in_boot_region", e.addr < 32'hf9020000, in_boot_region);
        end
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            fails++;
            print_verdict();
        end
    end
    initial
    begin
        void'($urandom(32'h50ef5393));
        repeat (8) @(negedge clk_sys);
        reset = 1'b0;
        chk("wait_setting", 32'h1e, wait_setting);
        fetch(3);
        @(negedge clk_sys);
        wait_wdata = 8'h03;
        wait_wr = 1'b1; // reset below must bring the default back
        @(negedge clk_sys);
        wait_wr = 1'b0;
        repeat (3) @(negedge clk_sys);
        reset = 1'b1; // abort the third read
        exp_q.delete();
        due_q.delete();
        pc = 32'hf9000000;
        repeat (8) @(negedge clk_sys);
        reset = 1'b0;
        fetch(1);
        for (int i = 0; i < 3; i++)
        begin
            @(negedge clk_sys);
            wait_wdata = (i == 0) ? 8'h00 : 8'($urandom % 6 + 1);
            wait_wr = 1'b1;
            n = (wait_wdata == 8'h00) ? 1 : int'(wait_wdata);
            @(negedge clk_sys);
            wait_wr = 1'b0;
            fetch(2);
            chk("wait_setting", wait_wdata, wait_setting);
        end
        settle();
        jump_addr = 32'hf901fffe;
        jump_valid = 1'b1;
        pc = jump_addr;
        @(negedge clk_sys);
        jump_valid = 1'b0;
        fetch(2);
        settle();
        for (int i = 1; i < 3; i++)
        begin
            {supply_ok_in, power_on_sense_in} = 2'(i);
            fetch_req = 1'b1;
            repeat (3) @(negedge clk_sys);
            chk("fetch_ready", 32'h0, fetch_ready);
            fetch_req = 1'b0;
            @(negedge clk_sys);
        end
        {supply_ok_in, power_on_sense_in} = 2'h3;
        fetch(1);
        settle();
        print_verdict();
    end
endmodule
bind bff_fetch bff_fetch_asserts u_bff_fetch_asserts (.clk_sys, .reset, .fetch_req,
    .fetch_ready, .flash_ce_n, .flash_oe_n, .flash_addr, .fetch_valid, .wait_setting);
`default_nettype wire
